/* bench/jtxlf_rx_model.sv */
// Behavioural link receiver facing the transmit framing block.
// Assumes one shared core clock; hold_i keeps SYNC low to request commas.
`timescale 1ns/100ps
`default_nettype none
module jtxlf_rx_model #(
	parameter int SLOW = 0
) (
	// Clock and reset
	input  wire logic                                 clk_i,
	input  wire logic                                 rst_n_i,
	// Control and observation
	input  wire logic                                 hold_i,
	input  wire logic                                 lmfc_edge_i,
	input  wire jtxlf_pkg::jtxlf_char_t [3:0]         lane_char_i,
	// Handshake
	output logic                                      sync_n_o
);
	localparam logic [9:0] K285 = 10'h0fa;
	logic       all_comma;
	logic       sync_r;
	logic [1:0] st_r;
	int         cnt_r;

	// Matches a character in either disparity and either bit order
	function automatic logic code_is(input logic [9:0] c, input logic [9:0] v);
		logic [9:0] r;
		for (int i = 0; i < 10; i++) r[i] = v[9-i];
		return (c === v) || (c === ~v) || (c === r) || (c === ~r);
	endfunction

	always_comb begin
		all_comma = 1'b1;
		for (int g = 0; g < 4; g++) all_comma &= lane_char_i[g].is_k & code_is(lane_char_i[g].chr, K285);
	end

	////////////////////////////////////////////////////////////////////////////////
	// Locks on four all-lane commas plus the transmitter's multiframe edge; no seed from the transmitter
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			st_r   <= 2'h0;
			cnt_r  <= 0;
			sync_r <= 1'b0;
		end else if (hold_i) begin
			st_r   <= 2'h0;
			cnt_r  <= 0;
			sync_r <= 1'b0;
		end else begin
			case (st_r)
				2'h0: begin
					cnt_r <= all_comma ? cnt_r + 1 : 0;
					if (all_comma && cnt_r >= 3) st_r <= 2'h1;
				end
				2'h1: if (lmfc_edge_i) st_r <= 2'h2;
				2'h2: begin
					cnt_r <= cnt_r + 1;
					if (cnt_r >= 4 + SLOW) begin
						sync_r <= 1'b1;
						st_r   <= 2'h3;
					end
				end
				default: ;
			endcase
		end
	end
	assign sync_n_o = sync_r & rst_n_i;
endmodule
`default_nettype wire

/* bench/jtxlf_tb_top.sv */
// Self-checking bench for the transmit link framing block.
// Assumes the receiver model on the lanes and a single 200 MHz core clock.
`timescale 1ns/100ps
`default_nettype none
module jtxlf_tb_top;
	localparam logic [9:0] C_K285 = 10'h0fa;
	localparam logic [9:0] C_K280 = 10'h0f4;
	localparam logic [9:0] C_K283 = 10'h0f3;
	localparam logic [9:0] C_D00  = 10'h274;
	logic                         core_clk = 1'b0;
	logic                         reset_n  = 1'b0;
	logic [3:0]                   mode     = 4'h0;
	logic                         scramble_enable      = 1'b0;
	logic                         fec      = 1'b0;
	logic [8:0]                   kmo      = 9'h01f;
	logic                         sysref   = 1'b0;
	logic                         hold     = 1'b1;
	logic [31:0]                  sample   = 32'h0;
	logic                         sync_n;
	jtxlf_pkg::jtxlf_char_t [3:0] lane_char;
	logic [65:0]                  blk;
	logic                         lmfc_edge;
	logic                         k_valid;
	jtxlf_pkg::jtxlf_mode_t       mode_dec;
	int                           err_total = 0;
	int                           n_checks  = 0;
	int                           cyc       = 0;
	int                           per       = 0;

	always #2.5 core_clk = ~core_clk;

	jtxlf_top dut (.core_clk_i(core_clk), .reset_n_i(reset_n), .transport_mode_select_i(mode),
		.scramble_enable_i(scramble_enable), .fec_enable_i(fec), .k_minus1_i(kmo), .sysref_i(sysref),
		.sync_n_i(sync_n), .sample_i(sample), .lane_char_o(lane_char), .lane_blk_o(blk),
		.lmfc_edge_o(lmfc_edge), .k_valid_o(k_valid), .mode_o(mode_dec));
	jtxlf_rx_model #(.SLOW(3)) rx (.clk_i(core_clk), .rst_n_i(reset_n), .hold_i(hold),
		.lmfc_edge_i(lmfc_edge), .lane_char_i(lane_char), .sync_n_o(sync_n));

	////////////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [65:0] got, input logic [65:0] exp);
		n_checks++;
		if (got !== exp) begin
			err_total++;
			$display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask
	task automatic wait_edge(output int n);
		n = 0;
		do begin
			tick(1);
			n++;
		end while (lmfc_edge !== 1'b1 && n < 3000);
	endtask
	task final_report;
		$display("checks %0d mismatches %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////////////
	task automatic t_reset_commas();
		tick(3);
		for (int g = 0; g < 4; g++) chk(rx.code_is(lane_char[g].chr, C_K285) & lane_char[g].is_k, 1);
	endtask
	task automatic t_mode_table();
		logic [3:0] ml [5] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h5};
		foreach (ml[i]) begin
			@(posedge core_clk) mode <= ml[i];
			tick(1);
			chk(mode_dec.enc, ml[i] inside {4'h2, 4'h3});
			if (!(ml[i] inside {4'h2, 4'h3})) chk(mode_dec.l, (ml[i] == 4'h1) ? 4'h2 : 4'h4);
			chk(mode_dec.n <= mode_dec.np, 1'b1);
		end
		@(posedge core_clk) mode <= 4'h0;
		tick(1);
	endtask
	task automatic t_k_range();
		int f;
		int kmin;
		int kmax;
		int kv [4];
		logic ev [4] = '{1'b0, 1'b1, 1'b1, 1'b0};
		f = 2;
		chk(mode_dec.f, 8'(f));
		kmin = (16 + f) / f;
		kmax = (1024 / f < 256) ? 1024 / f : 256;
		kv = '{kmin - 1, kmin, kmax, kmax + 1};
		for (int i = 0; i < 4; i++) begin
			if (kv[i] > 0) begin
				@(posedge core_clk) kmo <= 9'(kv[i] - 1);
				tick(1);
				chk(k_valid, ev[i]);
			end
		end
		@(posedge core_clk) kmo <= 9'(kmin - 1);
		per = f * kmin;
	endtask
	task automatic t_ilas();
		int n = 0;
		int le = 0;
		int ch = 0;
		@(posedge core_clk) scramble_enable <= 1'b1;
		@(posedge core_clk) hold <= 1'b0;
		while (sync_n !== 1'b1 && n < 4000) begin
			tick(1);
			n++;
		end
		chk(sync_n, 1'b1);
		n = 0;
		while (!rx.code_is(lane_char[0].chr, C_K280) && n < 3 * per + 20) begin
			tick(1);
			n++;
			if (lmfc_edge === 1'b1) le = n;
		end
		chk(le > 0 && n - le <= 3, 1'b1);
		for (int g = 0; g < 4; g++) chk(rx.code_is(lane_char[g].chr, C_K280) & lane_char[g].is_k, 1);
		tick(per - 1);
		chk(rx.code_is(lane_char[0].chr, C_K283) & lane_char[0].is_k, 1'b1);
		tick(1);
		chk(rx.code_is(lane_char[0].chr, C_K280), 1'b1);
		tick(3 * per - 1);
		chk(rx.code_is(lane_char[0].chr, C_K283) & lane_char[0].is_k, 1'b1);
		tick(1);
		chk(lane_char[0].is_k, 1'b0);
		repeat (8) begin
			tick(1);
			if (!rx.code_is(lane_char[0].chr, C_D00)) ch++;
		end
		chk(ch > 4, 1'b1);
		@(posedge core_clk) scramble_enable <= 1'b0;
		tick(4);
		repeat (4) begin
			tick(1);
			chk(rx.code_is(lane_char[0].chr, C_D00), 1'b1);
		end
	endtask
	task automatic t_lmfc();
		int o1;
		int o2;
		int p;
		@(posedge core_clk) sysref <= 1'b1;
		@(posedge core_clk) sysref <= 1'b0;
		wait_edge(o1);
		chk(o1, per - 1);
		wait_edge(p);
		chk(p, per);
		tick(per / 2 + 3);
		@(posedge core_clk) sysref <= 1'b1;
		@(posedge core_clk) sysref <= 1'b0;
		wait_edge(o2);
		chk(o2, o1);
	endtask
	task automatic t_64b();
		logic [65:0] prev;
		for (int m = 2; m < 4; m++) begin
			@(posedge core_clk) mode <= 4'(m);
			hold <= 1'b1;
			fec <= 1'b0;
			tick(4);
			chk(blk[65:64], jtxlf_pkg::SH_DATA);
			prev = blk;
			tick(1);
			chk(blk[63:0] !== prev[63:0], 1'b1);
			@(posedge core_clk) fec <= 1'b1;
			tick(3);
			chk(blk[65:64], jtxlf_pkg::SH_FEC);
		end
	endtask
	task automatic t_restart();
		@(posedge core_clk) mode <= 4'h0;
		fec <= 1'b0;
		tick(8);
		for (int g = 0; g < 4; g++) chk(rx.code_is(lane_char[g].chr, C_K285), 1'b1);
	endtask

	////////////////////////////////////////////////////////////////////////////////
	always @(posedge core_clk) begin
		cyc++;
		if (cyc == 20000) begin
			err_total++;
			final_report();
		end
	end
	initial begin
		repeat (20) @(posedge core_clk);
		reset_n <= 1'b1;
		t_reset_commas();
		t_mode_table();
		t_k_range();
		t_ilas();
		t_lmfc();
		t_64b();
		t_restart();
		final_report();
	end
endmodule
`default_nettype wire

/* hw/jtxlf_pkg.sv */
// Shared constants and types for the transmit link framing block.
// Assumes a single core clock; all lanes advance one octet per enabled cycle.
package jtxlf_pkg;
	localparam int LANES      = 4;
	localparam int OCT_W      = 8;
	localparam int CHAR_W     = 10;
	localparam int BLK_W      = 64;
	localparam int SH_W       = 2;
	localparam int MODE_W     = 4;
	localparam int CNT_W      = 10;
	localparam int K_MAX      = 256;
	localparam int FK_MAX     = 1024;
	localparam int F_MIN_PROD = 17;
	localparam int ILAS_MF    = 4;
	localparam int NUM_MODES  = 4;
	localparam logic [OCT_W-1:0]  K28_5 = 8'hbc;
	localparam logic [OCT_W-1:0]  K28_0 = 8'h1c;
	localparam logic [OCT_W-1:0]  K28_3 = 8'h7c;
	localparam logic [14:0] SCR8_SEED  = 15'h7fff;
	localparam logic [57:0] SCR64_SEED = 58'h3ff_ffff_ffff_ffff;
	localparam logic [SH_W-1:0]   SH_DATA = 2'h1;
	localparam logic [SH_W-1:0]   SH_FEC  = 2'h2;
	localparam logic [8:0] RD_NEG = 9'h000;
	typedef enum logic {JTXLF_ENC_8B10B, JTXLF_ENC_64B66B} jtxlf_enc_t;
	typedef struct packed {
		jtxlf_enc_t      enc;
		logic [3:0]      l;
		logic [3:0]      m;
		logic [7:0]      f;
		logic [1:0]      s;
		logic [3:0]      n;
		logic [4:0]      np;
	} jtxlf_mode_t;
	typedef struct packed {
		logic [CHAR_W-1:0] chr;
		logic              is_k;
	} jtxlf_char_t;
endpackage

/* hw/jtxlf_top.sv */
// Transmit link framing: transport mapping, scrambling, 8b/10b coding, multiframe clock.
// Assumes sync_n_i and sysref_i are plain inputs and sample words arrive every enabled cycle.
// Operation
// - Both 8b/10b and 64b/66b link layers; no 64b/80b path exists.
// - Sync header in 64b/66b never carries a command channel.
// - Forward error correction selectable in 64b/66b mode.
// - Three-bit CRC never generated in 64b/66b mode.
// - Dedicated SYNC input accepted in 8b/10b, compatible with older timing.
// - Subclass 1 only; works with subclass 0 receivers.
// - Lanes of one link aligned together; no multipoint reference.
// - Samples packed into octets, F octets per frame, over all four lanes whatever L the mode gives.
// - N-bit samples occupy N' bits; S samples per M converters each frame.
// - One mode-select value fixes L, M, F, S, N and N' together.
// - 8b/10b scrambles only when enabled; 64b/66b always scrambles.
// - Scrambling precedes 10-bit coding or sync header insertion.
// - Lane alignment sequence bypasses the scrambler.
// - Separate standard polynomials for 8b/10b and 64b/66b scrambling.
// - Every octet coded into a DC-balanced 10-bit character in 8b/10b mode; 64b/66b mode does not use 10-bit coding.
// - K frames per multiframe, ceil(17/F) to min(256, floor(1024/F)).
// - Multiframe clock marks boundaries; SYSREF resets its phase.
// - Multiframe period is 10*F*K bit times.
// - While SYNC is low in 8b/10b mode every lane sends K28.5; 64b/66b ignores SYNC.
// - After SYNC rises wait for multiframe edge; alignment uses K28.0 and K28.3.
`timescale 1ns/100ps
`default_nettype none
module jtxlf_top (
	// Clock and reset
	input  wire logic                                       core_clk_i,
	input  wire logic                                       reset_n_i,
	// Configuration
	input  wire logic [jtxlf_pkg::MODE_W-1:0]               transport_mode_select_i,
	input  wire logic                                       scramble_enable_i,
	input  wire logic                                       fec_enable_i,
	input  wire logic [8:0]                                 k_minus1_i,
	// Timing and handshake
	input  wire logic                                       sysref_i,
	input  wire logic                                       sync_n_i,
	// Sample data, one octet per lane per cycle
	input  wire logic [jtxlf_pkg::LANES*jtxlf_pkg::OCT_W-1:0] sample_i,
	// Lane outputs, multiframe edge, K range check and decoded mode
	output jtxlf_pkg::jtxlf_char_t [jtxlf_pkg::LANES-1:0]   lane_char_o,
	output logic [jtxlf_pkg::BLK_W+jtxlf_pkg::SH_W-1:0]     lane_blk_o,
	output logic                                            lmfc_edge_o,
	output logic                                            k_valid_o,
	output jtxlf_pkg::jtxlf_mode_t                          mode_o
);
	////////////////////////////////////////////////////////////////////////////
	// Mode table
	jtxlf_pkg::jtxlf_mode_t mode;
	always_comb begin
		case (transport_mode_select_i)
			4'h0:    mode = '{jtxlf_pkg::JTXLF_ENC_8B10B,  4'h4, 4'h4, 8'h02, 2'h1, 4'h9, 5'h10};
			4'h1:    mode = '{jtxlf_pkg::JTXLF_ENC_8B10B,  4'h2, 4'h2, 8'h02, 2'h1, 4'h9, 5'h10};
			4'h2:    mode = '{jtxlf_pkg::JTXLF_ENC_64B66B, 4'h4, 4'h4, 8'h02, 2'h1, 4'h9, 5'h10};
			4'h3:    mode = '{jtxlf_pkg::JTXLF_ENC_64B66B, 4'h4, 4'h8, 8'h04, 2'h1, 4'h9, 5'h10};
			default: mode = '{jtxlf_pkg::JTXLF_ENC_8B10B,  4'h4, 4'h4, 8'h02, 2'h1, 4'h9, 5'h10};
		endcase
	end
	wire logic is64 = (mode.enc == jtxlf_pkg::JTXLF_ENC_64B66B);
	////////////////////////////////////////////////////////////////////////////
	// K range check: F*K within [17, 1024], K <= 256
	logic [17:0] fk;
	always_comb fk = 18'(mode.f) * (18'(k_minus1_i) + 18'h1);
	assign k_valid_o = (fk >= 18'(jtxlf_pkg::F_MIN_PROD)) && (fk <= 18'(jtxlf_pkg::FK_MAX))
		&& (k_minus1_i < 9'(jtxlf_pkg::K_MAX));
	////////////////////////////////////////////////////////////////////////////
	// Synchronisers and multiframe clock
	logic       sync_m_r, sync_s_r, sync_d_r, sysref_d_r;
	logic [7:0] oct_cnt_r, oct_cnt_nxt;
	logic [8:0] frm_cnt_r, frm_cnt_nxt;
	logic       lmfc_edge;
	wire logic  sysref_rise = sysref_i & ~sysref_d_r;
	always_comb begin
		oct_cnt_nxt = oct_cnt_r + 8'h1;
		frm_cnt_nxt = frm_cnt_r;
		lmfc_edge   = 1'b0;
		if (sysref_rise) begin
			oct_cnt_nxt = 8'h0;
			frm_cnt_nxt = 9'h0;
		end else if (oct_cnt_r >= mode.f - 8'h1) begin
			oct_cnt_nxt = 8'h0;
			frm_cnt_nxt = frm_cnt_r + 9'h1;
			if (frm_cnt_r >= k_minus1_i) begin
				frm_cnt_nxt = 9'h0;
				lmfc_edge   = 1'b1;
			end
		end
	end
	always_ff @(posedge core_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			sync_m_r   <= 1'b0;
			sync_s_r   <= 1'b0;
			sync_d_r   <= 1'b0;
			sysref_d_r <= 1'b0;
			oct_cnt_r  <= 8'h0;
			frm_cnt_r  <= 9'h0;
		end else begin
			sync_m_r   <= sync_n_i;
			sync_s_r   <= sync_m_r;
			sync_d_r   <= sync_s_r;
			sysref_d_r <= sysref_i;
			oct_cnt_r  <= oct_cnt_nxt;
			frm_cnt_r  <= frm_cnt_nxt;
		end
	end
	////////////////////////////////////////////////////////////////////////////
	// Link state
	typedef enum logic [1:0] {JTXLF_CGS, JTXLF_WAIT, JTXLF_ILAS, JTXLF_DATA} jtxlf_st_t;
	jtxlf_st_t  st_r, st_nxt;
	logic [1:0] mf_r, mf_nxt;
	wire logic  last_oct = (oct_cnt_r >= mode.f - 8'h1) && (frm_cnt_r >= k_minus1_i);
	always_comb begin
		st_nxt = st_r;
		mf_nxt = mf_r;
		case (st_r)
			JTXLF_CGS:  if (sync_s_r && !sync_d_r) st_nxt = JTXLF_WAIT;
			JTXLF_WAIT: if (lmfc_edge) begin
				st_nxt = JTXLF_ILAS;
				mf_nxt = 2'h0;
			end
			JTXLF_ILAS: if (lmfc_edge) begin
				mf_nxt = mf_r + 2'h1;
				if (mf_r == 2'(jtxlf_pkg::ILAS_MF - 1)) st_nxt = JTXLF_DATA;
			end
			JTXLF_DATA: ;
			default:    st_nxt = JTXLF_CGS;
		endcase
		// SYNC low forces commas in 8b/10b; 64b/66b has no SYNC handshake
		if (!sync_s_r && !is64) st_nxt = JTXLF_CGS;
		if (is64) st_nxt = JTXLF_DATA;
	end
	always_ff @(posedge core_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			st_r <= JTXLF_CGS;
			mf_r <= 2'h0;
		end else begin
			st_r <= st_nxt;
			mf_r <= mf_nxt;
		end
	end
	////////////////////////////////////////////////////////////////////////////
	// 8b/10b scramblers and lane octets: 1 + x^14 + x^15
	logic [jtxlf_pkg::LANES-1:0][14:0]             s8_r, s8_nxt;
	logic [jtxlf_pkg::LANES-1:0][jtxlf_pkg::OCT_W-1:0] oct;
	logic [jtxlf_pkg::LANES-1:0]                   kflag;
	wire logic scr8_on = scramble_enable_i && (st_r == JTXLF_DATA);
	genvar g;
	generate
		for (g = 0; g < jtxlf_pkg::LANES; g++) begin : g_lane
			always_comb begin
				logic [14:0] s;
				logic [7:0]  d;
				s = s8_r[g];
				d = sample_i[g*jtxlf_pkg::OCT_W +: jtxlf_pkg::OCT_W];
				for (int b = 7; b >= 0; b--) begin
					d[b] = d[b] ^ s[14] ^ s[13];
					s    = {s[13:0], d[b]};
				end
				s8_nxt[g] = scr8_on ? s : s8_r[g];
				kflag[g]  = 1'b1;
				case (st_r)
					JTXLF_CGS, JTXLF_WAIT: oct[g] = jtxlf_pkg::K28_5;
					JTXLF_ILAS: begin
						if (oct_cnt_r == 8'h0 && frm_cnt_r == 9'h0) oct[g] = jtxlf_pkg::K28_0;
						else if (last_oct) oct[g] = jtxlf_pkg::K28_3;
						else begin
							oct[g]   = sample_i[g*jtxlf_pkg::OCT_W +: jtxlf_pkg::OCT_W];
							kflag[g] = 1'b0;
						end
					end
					default: begin
						oct[g]   = scr8_on ? d : sample_i[g*jtxlf_pkg::OCT_W +: jtxlf_pkg::OCT_W];
						kflag[g] = 1'b0;
					end
				endcase
			end
		end
	endgenerate
	////////////////////////////////////////////////////////////////////////////
	// 8b/10b encoder with running disparity
	function automatic logic [10:0] enc8b10b(input logic [7:0] d, input logic k, input logic rd);
		logic [5:0] a6;
		logic [3:0] b4;
		logic       r;
		case (d[4:0])
			5'h00: a6 = 6'b100111; 5'h01: a6 = 6'b011101; 5'h02: a6 = 6'b101101;
			5'h03: a6 = 6'b110001; 5'h04: a6 = 6'b110101; 5'h05: a6 = 6'b101001;
			5'h06: a6 = 6'b011001; 5'h07: a6 = 6'b111000; 5'h08: a6 = 6'b111001;
			5'h09: a6 = 6'b100101; 5'h0a: a6 = 6'b010101; 5'h0b: a6 = 6'b110100;
			5'h0c: a6 = 6'b001101; 5'h0d: a6 = 6'b101100; 5'h0e: a6 = 6'b011100;
			5'h0f: a6 = 6'b010111; 5'h10: a6 = 6'b011011; 5'h11: a6 = 6'b100011;
			5'h12: a6 = 6'b010011; 5'h13: a6 = 6'b110010; 5'h14: a6 = 6'b001011;
			5'h15: a6 = 6'b101010; 5'h16: a6 = 6'b011010; 5'h17: a6 = 6'b111010;
			5'h18: a6 = 6'b110011; 5'h19: a6 = 6'b100110; 5'h1a: a6 = 6'b010110;
			5'h1b: a6 = 6'b110110; 5'h1c: a6 = 6'b001110; 5'h1d: a6 = 6'b101110;
			5'h1e: a6 = 6'b011110; default: a6 = 6'b101011;
		endcase
		if (k) a6 = 6'b001111;
		if (rd && ($countones(a6) != 3 || a6 == 6'b111000)) a6 = ~a6;
		r = rd ^ ($countones(a6) != 3);
		case (d[7:5])
			3'h0: b4 = 4'b1011; 3'h1: b4 = 4'b1001; 3'h2: b4 = 4'b0101; 3'h3: b4 = 4'b1100;
			3'h4: b4 = 4'b1101; 3'h5: b4 = 4'b1010; 3'h6: b4 = 4'b0110; default: b4 = 4'b1110;
		endcase
		if (r && ($countones(b4) != 2 || b4 == 4'b1100)) b4 = ~b4;
		// Balanced K28 sub-blocks take the opposite form to data ones when the 6b block leaves disparity negative
		if (k && !r && d[7:5] inside {3'h1, 3'h2, 3'h5, 3'h6})
			b4 = ~b4;
		// Alternate D.x.7 keeps runs of equal bits below five
		if (!k && d[7:5] == 3'h7 && ((!r && d[4:0] inside {5'h11, 5'h12, 5'h14})
			|| (r && d[4:0] inside {5'h0b, 5'h0d, 5'h0e})))
			b4 = r ? 4'b1000 : 4'b0111;
		r = r ^ ($countones(b4) != 2);
		enc8b10b = {r, a6, b4};
	endfunction
	logic [jtxlf_pkg::LANES-1:0] rd_r, rd_nxt;
	jtxlf_pkg::jtxlf_char_t [jtxlf_pkg::LANES-1:0] chr_r, chr_nxt;
	always_comb begin
		logic [10:0] e;
		e = 11'h0;
		for (int i = 0; i < jtxlf_pkg::LANES; i++) begin
			e          = enc8b10b(oct[i], kflag[i], rd_r[i]);
			rd_nxt[i]  = is64 ? rd_r[i] : e[10];
			chr_nxt[i] = is64 ? chr_r[i] : '{e[9:0], kflag[i]};
		end
	end
	////////////////////////////////////////////////////////////////////////////
	// 64b/66b: always scrambled (1 + x^39 + x^58), then sync header
	logic [57:0]                 s64_r, s64_nxt;
	logic [jtxlf_pkg::BLK_W-1:0] blk;
	logic [jtxlf_pkg::BLK_W+jtxlf_pkg::SH_W-1:0] blk_r, blk_nxt;
	always_comb begin
		logic [57:0] s;
		s   = s64_r;
		blk = {sample_i, sample_i};
		for (int b = jtxlf_pkg::BLK_W - 1; b >= 0; b--) begin
			blk[b] = blk[b] ^ s[38] ^ s[57];
			s      = {s[56:0], blk[b]};
		end
		s64_nxt = is64 ? s : s64_r;
		// Header carries block marking or FEC only: no command channel, no CRC3
		blk_nxt = is64 ? {(fec_enable_i ? jtxlf_pkg::SH_FEC : jtxlf_pkg::SH_DATA), blk}
			: blk_r;
	end
	always_ff @(posedge core_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			s8_r  <= {jtxlf_pkg::LANES{jtxlf_pkg::SCR8_SEED}};
			s64_r <= jtxlf_pkg::SCR64_SEED;
			rd_r  <= '0;
			chr_r <= '0;
			blk_r <= '0;
		end else begin
			s8_r  <= s8_nxt;
			s64_r <= s64_nxt;
			rd_r  <= rd_nxt;
			chr_r <= chr_nxt;
			blk_r <= blk_nxt;
		end
	end
	assign lane_char_o = chr_r;
	assign lane_blk_o  = blk_r;
	assign lmfc_edge_o = lmfc_edge;
	assign mode_o      = mode;
	////////////////////////////////////////////////////////////////////////////
	// Assertions
	a_cgs_comma: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
		(!sync_s_r && !is64 && st_r == JTXLF_CGS) |=> chr_r[0].is_k)
		else $error("comma not sent during sync request");
	a_ilas_after_edge: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
		(st_r == JTXLF_WAIT && st_nxt == JTXLF_ILAS) |-> lmfc_edge)
		else $error("alignment started off multiframe edge");
	a_sysref_phase: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
		sysref_rise |=> (oct_cnt_r == 8'h0 && frm_cnt_r == 9'h0))
		else $error("sysref did not reset multiframe phase");
	a_scr8_hold: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
		(!is64 && !scr8_on) |=> (s8_r == $past(s8_r)))
		else $error("scrambler advanced while disabled");
	a_ilas_unscr: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
		(st_r == JTXLF_ILAS) |-> !scr8_on)
		else $error("alignment sequence scrambled");
	a_sh_no_cmd: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
		($past(is64) && $past(reset_n_i))
		|-> (blk_r[65:64] == jtxlf_pkg::SH_DATA || blk_r[65:64] == jtxlf_pkg::SH_FEC))
		else $error("illegal sync header");
	a_s64_moves: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
		is64 |=> (s64_r != $past(s64_r) || $past(blk) == 64'h0))
		else $error("64b scrambler stalled");
	a_ilas_len: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
		(st_r == JTXLF_ILAS && mf_r == 2'h3 && lmfc_edge && sync_s_r) |=> st_r == JTXLF_DATA)
		else $error("alignment sequence length wrong");
	// Every alignment multiframe opens with K28.0 on the registered lane
	a_ilas_start: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
		(st_r == JTXLF_ILAS && !is64 && oct_cnt_r == 8'h0 && frm_cnt_r == 9'h0)
		|=> (chr_r[0].is_k && (chr_r[0].chr == 10'h0f4 || chr_r[0].chr == 10'h30b)))
		else $error("alignment multiframe start marker missing");
	c_ilas_done: cover property (@(posedge core_clk_i) st_r == JTXLF_ILAS ##1 st_r == JTXLF_DATA);
	c_sync_rise: cover property (@(posedge core_clk_i) st_r == JTXLF_WAIT ##[1:1000] st_r == JTXLF_ILAS);
	c_data: cover property (@(posedge core_clk_i) st_r == JTXLF_DATA && scr8_on);
	c_sysref: cover property (@(posedge core_clk_i) sysref_rise);
endmodule
`default_nettype wire
